// ==== test/tb_msrb_bank.sv ====
// Self-checking testbench for the status register bank: drives the strobe
// bus, the flush and machine check pins, and checks reads and outputs.
// Assumes the bank answers reads one cycle after the strobe and never waits.
`timescale 1ns/1ps
module tb_msrb_bank;
  import msrb_pkg::*;

  logic core_clk;
  logic srst;
  msrb_bus_req_type bus_req;
  logic [63:0] bus_rdata;
  logic [2:0] bus_speed_code;
  logic mgmt_range_supported;
  logic l2_hw_enabled;
  logic l2_absent;
  logic writeback_invalidate_instr;
  logic cache_flush_n;
  logic core_active;
  msrb_mc_event_type mc_event;
  logic flush_start;
  logic mc_exception;
  logic shutdown;
  logic irq;
  int errors;
  int compares;
  int flush_cnt;
  int mc_cnt;
  logic [63:0] rv;
  logic [63:0] rv2;

  msrb_bank dut (
    .core_clk(core_clk),
    .srst(srst),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .bus_speed_code(bus_speed_code),
    .mgmt_range_supported(mgmt_range_supported),
    .l2_hw_enabled(l2_hw_enabled),
    .l2_absent(l2_absent),
    .writeback_invalidate_instr(writeback_invalidate_instr),
    .cache_flush_n(cache_flush_n),
    .core_active(core_active),
    .mc_event(mc_event),
    .flush_start(flush_start),
    .mc_exception(mc_exception),
    .shutdown(shutdown),
    .irq(irq)
  );

  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Output pulses are counted so that a missing or extra pulse shows up.
  always @(posedge core_clk) begin
    if (flush_start === 1'b1) flush_cnt++;
    if (mc_exception === 1'b1) mc_cnt++;
  end

  task automatic chk(input string name, input logic [63:0] seen,
                     input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Each access leaves one idle edge behind it, so strobes never collide.
  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [63:0] d);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 64'h0};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
    d = bus_rdata;
  endtask

  // Write then read back with no idle edge between the two strobes.
  task automatic wr_rd(input logic [11:0] a, input logic [63:0] w,
                       output logic [63:0] d);
    @(posedge core_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
    @(posedge core_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 64'h0};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
    d = bus_rdata;
  endtask

  task automatic pulse_mc(input logic ro, input logic ei);
    @(posedge core_clk);
    mc_event <= '{valid: 1'b1, restart_ok: ro, error_ip: ei};
    @(posedge core_clk);
    mc_event <= '0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  // One flush request from each source, then time for the answer to land.
  task automatic flush_both();
    @(posedge core_clk);
    writeback_invalidate_instr <= 1'b1;
    @(posedge core_clk);
    writeback_invalidate_instr <= 1'b0;
    cache_flush_n <= 1'b0;
    @(posedge core_clk);
    cache_flush_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // The tests need under two hundred cycles; this limit leaves a wide margin.
  initial begin
    #50000;
    errors++;
    tally_and_finish();
  end

  // Main sequence of tests.
  initial begin
    errors = 0;
    compares = 0;
    flush_cnt = 0;
    mc_cnt = 0;
    srst = 1'b1;
    bus_req = '0;
    bus_speed_code = 3'h0;
    mgmt_range_supported = 1'b1;
    l2_hw_enabled = 1'b1;
    l2_absent = 1'b0;
    writeback_invalidate_instr = 1'b0;
    cache_flush_n = 1'b1;
    core_active = 1'b0;
    mc_event = '0;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    rd(12'h11E, rv);
    chk("l2_ctl_reset", rv, 64'h0000_0000_0000_0001);
    l2_hw_enabled <= 1'b0;
    l2_absent <= 1'b1;
    rd(12'h11E, rv);
    chk("l2_ctl_pins", rv, 64'h0000_0000_0080_0000);
    // Every bus speed code must come back alone in the low field.
    for (int i = 0; i < 8; i++) begin
      bus_speed_code <= i[2:0];
      rd(12'h0CD, rv);
      chk("bus_speed", rv, {61'h0, i[2:0]});
    end
    wr(12'h0FE, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(12'h0FE, rv);
    chk("range_cap_set", rv, 64'h0000_0000_0000_0800);
    mgmt_range_supported <= 1'b0;
    rd(12'h0FE, rv);
    chk("range_cap_clr", rv, 64'h0000_0000_0000_0000);
    // Flush requests before the cache is marked ready go unanswered.
    flush_both();
    chk("flush_ignored", flush_cnt, 64'h0);
    rd(12'h300, rv);
    chk("status_ign", rv, 64'h0000_0000_0000_0008);
    chk("irq_masked", irq, 1'b0);
    wr(12'h301, 64'h0000_0000_0000_0008);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq_on", irq, 1'b1);
    rd(12'h301, rv);
    chk("mask_read", rv, 64'h0000_0000_0000_0008);
    wr(12'h300, 64'h0000_0000_0000_0008);
    repeat (2) @(posedge core_clk);
    #1;
    chk("irq_off", irq, 1'b0);
    l2_hw_enabled <= 1'b1;
    l2_absent <= 1'b0;
    wr_rd(12'h11E, 64'hFFFF_FFFF_FFFF_FFFF, rv);
    chk("l2_ctl_wr", rv, 64'h0000_0000_0000_0101);
    flush_both();
    chk("flush_done", flush_cnt, 64'h2);
    rd(12'h300, rv);
    chk("status_done", rv, 64'h0000_0000_0000_0004);
    // Machine checks: first one delivered, re-armed by software, a second
    // one delivered, then a third while the flag is still set must end in shutdown.
    wr(12'h300, 64'h0000_0000_0000_000F);
    pulse_mc(1'b1, 1'b0);
    chk("mc_first", mc_cnt, 64'h1);
    rd(12'h17A, rv);
    chk("err_state_a", rv, 64'h0000_0000_0000_0005);
    wr(12'h17A, 64'h0000_0000_0000_0000);
    rd(12'h17A, rv);
    chk("err_state_clr", rv, 64'h0000_0000_0000_0000);
    pulse_mc(1'b0, 1'b1);
    chk("mc_second", mc_cnt, 64'h2);
    rd(12'h17A, rv);
    chk("err_state_b", rv, 64'h0000_0000_0000_0006);
    chk("no_shutdown", shutdown, 1'b0);
    pulse_mc(1'b1, 1'b1);
    chk("shutdown_on", shutdown, 1'b1);
    chk("mc_no_third", mc_cnt, 64'h2);
    rd(12'h300, rv);
    chk("status_mc", rv, 64'h0000_0000_0000_0003);
    pulse_mc(1'b1, 1'b0);
    chk("mc_after_shut", mc_cnt, 64'h2);
    // Reads two cycles apart see the free-running counter move by two.
    rd(12'h0E7, rv);
    rd(12'h0E7, rv2);
    chk("max_perf_step", rv2 - rv, 64'h2);
    wr(12'h0E8, 64'h0000_0000_0000_1234);
    rd(12'h0E8, rv);
    chk("act_perf_load", rv, 64'h0000_0000_0000_1234);
    @(posedge core_clk);
    core_active <= 1'b1;
    repeat (10) @(posedge core_clk);
    core_active <= 1'b0;
    rd(12'h0E8, rv);
    chk("act_perf_count", rv, 64'h0000_0000_0000_123E);
    // Plain storage words keep distinct values; a hole reads zero.
    for (int i = 0; i < NUM_GEN; i++) wr(GEN_ADDRS[i], 64'hA5A5_0000 + i);
    for (int i = 0; i < NUM_GEN; i++) begin
      rd(GEN_ADDRS[i], rv);
      chk("storage", rv, 64'hA5A5_0000 + i);
    end
    wr(12'h123, 64'hFFFF_FFFF_FFFF_FFFF);
    rd(12'h123, rv);
    chk("unmapped", rv, 64'h0000_0000_0000_0000);
    rd(12'h179, rv);
    chk("err_cap", rv, ERR_CAP_VALUE);
    // A reset in mid-run is the only way out of shutdown.
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk("shutdown_rst", shutdown, 1'b0);
    rd(12'h11E, rv);
    chk("l2_init_rst", rv, 64'h0000_0000_0000_0001);
    pulse_mc(1'b0, 1'b0);
    chk("mc_after_rst", mc_cnt, 64'h3);
    tally_and_finish();
  end
endmodule

// ==== verilog/msrb_bank.sv ====
// Model-specific status register bank: L2 control, global error state,
// capability words, performance counters and plain storage words.
// Assumes a single-cycle strobe bus that never waits and synchronous pins.
`timescale 1ns/1ps
module msrb_bank (
  input wire logic core_clk,
  input wire logic srst,
  input msrb_pkg::msrb_bus_req_type bus_req,
  output logic [msrb_pkg::DATA_W-1:0] bus_rdata,
  input wire logic [msrb_pkg::BUS_CODE_W-1:0] bus_speed_code,
  input wire logic mgmt_range_supported,
  input wire logic l2_hw_enabled,
  input wire logic l2_absent,
  input wire logic writeback_invalidate_instr,
  input wire logic cache_flush_n,
  input wire logic core_active,
  input msrb_pkg::msrb_mc_event_type mc_event,
  output logic flush_start,
  output logic mc_exception,
  output logic shutdown,
  output logic irq
);
  import msrb_pkg::*;

  msrb_state_type q;
  msrb_state_type d;
  logic [NUM_CNT-1:0] cnt_load;
  logic [NUM_CNT-1:0] cnt_en;
  logic [NUM_CNT-1:0][63:0] cnt_val;
  logic flush_req;
  logic mc_accept;
  logic mc_second;
  logic [3:0] ev;

  // The maximum count runs every cycle, the actual count only while the
  // core is active, so their ratio tracks the effective speed.
  assign cnt_en[0] = 1'b1;
  assign cnt_en[1] = core_active;

  // One counter per performance count, loaded by a write to its address.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
      assign cnt_load[gi] = bus_req.wr && bus_req.addr == CNT_ADDRS[gi];
      msrb_counter u_cnt (
        .core_clk(core_clk),
        .srst(srst),
        .load(cnt_load[gi]),
        .load_value(bus_req.wdata),
        .count_en(cnt_en[gi]),
        .value(cnt_val[gi])
      );
    end
  endgenerate

  // Flush requests come from the instruction or a new low level on the
  // external input; a held-low input counts only once.
  assign flush_req = writeback_invalidate_instr ||
    (!cache_flush_n && q.flush_n_prev);

  // A machine check is taken only when not shut down and no check is in progress.
  assign mc_accept = mc_event.valid && !q.shutdown && !q.err_state[CIP_BIT];
  assign mc_second = mc_event.valid && !q.shutdown && q.err_state[CIP_BIT];

  // Next-state logic for the whole bank.
  always_comb begin
    d = q;
    d.rdata = '0;
    d.flush_start = 1'b0;
    d.mc_exception = 1'b0;
    d.flush_n_prev = cache_flush_n;
    ev = '0;

    // Software writes; reserved bits are simply not stored.
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        ADDR_L2_CTL: begin
          d.l2_init = bus_req.wdata[L2_INIT_BIT];
        end
        ADDR_ERR_STATE: begin
          d.err_state = bus_req.wdata[2:0];
        end
        ADDR_EV_STATUS: begin
          d.ev_stat = q.ev_stat & ~bus_req.wdata[3:0];
        end
        ADDR_EV_MASK: begin
          d.ev_mask = bus_req.wdata[3:0];
        end
        default: begin
          for (int i = 0; i < NUM_GEN; i++) begin
            if (bus_req.addr == GEN_ADDRS[i]) begin
              d.gen[i] = bus_req.wdata;
            end
          end
        end
      endcase
    end

    // Flushes are only honoured after software declares the L2 ready;
    // an ignored request is still reported as an event.
    if (flush_req) begin
      if (q.l2_init) begin
        d.flush_start = 1'b1;
        ev[EV_FLUSH_DONE] = 1'b1;
      end else begin
        ev[EV_FLUSH_IGN] = 1'b1;
      end
    end

    // Hardware machine-check update comes after the software write so
    // that a same-cycle check is never lost.
    if (mc_accept) begin
      d.err_state[RESTART_BIT] = mc_event.restart_ok;
      d.err_state[ERR_PTR_BIT] = mc_event.error_ip;
      d.err_state[CIP_BIT] = 1'b1;
      d.mc_exception = 1'b1;
      ev[EV_MC_TAKEN] = 1'b1;
    end else if (mc_second) begin
      // Shutdown is sticky until reset; no exception is delivered.
      d.err_state[CIP_BIT] = 1'b1;
      d.shutdown = 1'b1;
      ev[EV_SHUTDOWN] = 1'b1;
    end

    // Sticky events: a set in the clearing cycle wins.
    d.ev_stat = d.ev_stat | ev;
    d.irq = |(d.ev_stat & d.ev_mask);

    // Read data stand for exactly one cycle after the read strobe.
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_BUS_SPEED: begin
          d.rdata[BUS_CODE_W-1:0] = bus_speed_code;
        end
        ADDR_MAX_PERF: begin
          d.rdata = cnt_val[0];
        end
        ADDR_ACT_PERF: begin
          d.rdata = cnt_val[1];
        end
        ADDR_MRANGE_CAP: begin
          d.rdata[MGMT_RANGE_BIT] = mgmt_range_supported;
        end
        ADDR_L2_CTL: begin
          d.rdata[L2_HW_EN_BIT] = l2_hw_enabled;
          d.rdata[L2_INIT_BIT] = q.l2_init;
          d.rdata[L2_ABSENT_BIT] = l2_absent;
        end
        ADDR_ERR_CAP: begin
          d.rdata = ERR_CAP_VALUE;
        end
        ADDR_ERR_STATE: begin
          d.rdata[2:0] = q.err_state;
        end
        ADDR_EV_STATUS: begin
          d.rdata[EV_W-1:0] = q.ev_stat;
        end
        ADDR_EV_MASK: begin
          d.rdata[EV_W-1:0] = q.ev_mask;
        end
        default: begin
          // Unmapped addresses read as zero.
          for (int i = 0; i < NUM_GEN; i++) begin
            if (bus_req.addr == GEN_ADDRS[i]) begin
              d.rdata = q.gen[i];
            end
          end
        end
      endcase
    end
  end

  // State register; the reset value keeps the flush input inactive.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // Every output comes straight from the state register.
  assign bus_rdata = q.rdata;
  assign flush_start = q.flush_start;
  assign mc_exception = q.mc_exception;
  assign shutdown = q.shutdown;
  assign irq = q.irq;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_mrange_flag_read: assert property (
    bus_req.rd && bus_req.addr == ADDR_MRANGE_CAP |=>
      bus_rdata[MGMT_RANGE_BIT] == $past(mgmt_range_supported))
    else $error("Range capability flag read back wrong.");

  a_l2_hw_flag: assert property (
    bus_req.rd && bus_req.addr == ADDR_L2_CTL |=>
      bus_rdata[L2_HW_EN_BIT] == $past(l2_hw_enabled))
    else $error("L2 hardware enable flag read back wrong.");

  a_l2_init_write: assert property (
    bus_req.wr && bus_req.addr == ADDR_L2_CTL ##1
      bus_req.rd && bus_req.addr == ADDR_L2_CTL |=>
      bus_rdata[L2_INIT_BIT] == $past(bus_req.wdata[L2_INIT_BIT], 2))
    else $error("L2 initialised bit did not follow the write.");

  a_flush_gated_init: assert property (
    flush_start |-> $past(q.l2_init) && $past(flush_req))
    else $error("Flush started while L2 not initialised.");

  a_flush_ignored: assert property (
    flush_req && !q.l2_init |=> !flush_start)
    else $error("Flush request not ignored before initialisation.");

  a_l2_absent_flag: assert property (
    bus_req.rd && bus_req.addr == ADDR_L2_CTL |=>
      bus_rdata[L2_ABSENT_BIT] == $past(l2_absent))
    else $error("L2 absent flag read back wrong.");

  a_restart_capture: assert property (
    mc_accept |=> q.err_state[RESTART_BIT] == $past(mc_event.restart_ok))
    else $error("Restart valid flag not captured.");

  a_errptr_capture: assert property (
    mc_accept |=> q.err_state[ERR_PTR_BIT] == $past(mc_event.error_ip))
    else $error("Error pointer flag not captured.");

  a_cip_set_check: assert property (
    mc_accept |=> q.err_state[CIP_BIT] && mc_exception ##1 !mc_exception)
    else $error("Check in progress not set on machine check.");

  a_shutdown_entry: assert property (
    mc_event.valid && q.err_state[CIP_BIT] |=> shutdown && !mc_exception)
    else $error("Second machine check did not shut down.");

  a_shutdown_sticky: assert property (
    shutdown |=> shutdown && !mc_exception)
    else $error("Shutdown state left without reset.");

  a_reserved_zero: assert property (
    bus_req.rd && bus_req.addr == ADDR_L2_CTL |=>
      bus_rdata[7:1] == '0 && bus_rdata[22:9] == '0 &&
      bus_rdata[63:24] == '0)
    else $error("Reserved L2 control bits read nonzero.");

  a_rdata_one_cycle: assert property (
    !bus_req.rd |=> bus_rdata == '0)
    else $error("Read data present without a read.");

  c_flush_done: cover property (flush_start);
  c_flush_ignored: cover property (flush_req && !q.l2_init);
  c_shutdown: cover property ($rose(shutdown));
  c_irq_raised: cover property ($rose(irq));

endmodule

// ==== verilog/msrb_counter.sv ====
// One loadable 64-bit clock counter for the performance count pair.
// Assumes load and count enable are synchronous to core_clk.
`timescale 1ns/1ps
module msrb_counter (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [msrb_pkg::DATA_W-1:0] load_value,
  input wire logic count_en,
  output logic [msrb_pkg::DATA_W-1:0] value
);
  import msrb_pkg::*;

  msrb_cnt_state_type q;
  msrb_cnt_state_type d;

  // A software load beats counting so the written value reads back exactly.
  always_comb begin
    d = q;
    if (load) begin
      d.value = load_value;
    end else if (count_en) begin
      d.value = q.value + 64'h0000_0000_0000_0001;
    end
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q.value <= CNT_RESET;
    end else begin
      q <= d;
    end
  end

  assign value = q.value;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_counter_load_value: assert property (
    load |=> value == $past(load_value))
    else $error("Counter did not take the written value.");

  a_counter_hold_idle: assert property (
    !load && !count_en |=> value == $past(value))
    else $error("Counter moved without load or count enable.");

endmodule

// ==== verilog/msrb_pkg.sv ====
// Package for the model-specific status register slice: addresses, fields,
// reset values and carrier types shared by the bank and its counters.
// Assumes one 100 MHz clock with synchronous active-high reset.
// Overview of operation
// - Bit 11 of the memory range capability register is a read-only flag telling whether the management mode range registers at 0A0H and 0A1H exist.
// - Bit 0 of the L2 control register is read-only and shows 1 when the L2 cache is hardware-enabled, else 0.
// - Bit 8 of the L2 control register is read/write, resets to 0, and software sets it once the L2 cache is initialised.
// - While bit 8 is clear, write-back-and-invalidate requests and the external flush input are ignored.
// - Bit 0 of the global error state register is set when the saved instruction pointer can restart the program.
// - Bit 1 of the global error state register is set when the saved instruction pointer is tied to the error.
// - Bit 2 of the global error state register is set by hardware whenever a machine check is generated.
// - A machine check arriving while bit 2 is still set sends the processor to shutdown instead of a new exception.
// - The maximum and actual performance clock counts are separate read/write counters at E7H and E8H.
package msrb_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 64;
  localparam int NUM_CNT = 2;
  localparam int NUM_GEN = 5;
  localparam int EV_W = 4;
  localparam int BUS_CODE_W = 3;

  // Register addresses, as register indices.
  localparam logic [11:0] ADDR_BUS_SPEED = 12'h0CD;
  localparam logic [11:0] ADDR_MAX_PERF = 12'h0E7;
  localparam logic [11:0] ADDR_ACT_PERF = 12'h0E8;
  localparam logic [11:0] ADDR_MRANGE_CAP = 12'h0FE;
  localparam logic [11:0] ADDR_L2_CTL = 12'h11E;
  localparam logic [11:0] ADDR_FC_CS = 12'h174;
  localparam logic [11:0] ADDR_FC_SP = 12'h175;
  localparam logic [11:0] ADDR_FC_IP = 12'h176;
  localparam logic [11:0] ADDR_ERR_CAP = 12'h179;
  localparam logic [11:0] ADDR_ERR_STATE = 12'h17A;
  localparam logic [11:0] ADDR_EVSEL0 = 12'h186;
  localparam logic [11:0] ADDR_EVSEL1 = 12'h187;
  localparam logic [11:0] ADDR_EV_STATUS = 12'h300;
  localparam logic [11:0] ADDR_EV_MASK = 12'h301;

  // Counter and plain storage address tables, entry 0 last.
  localparam logic [1:0][11:0] CNT_ADDRS = {ADDR_ACT_PERF, ADDR_MAX_PERF};
  localparam logic [4:0][11:0] GEN_ADDRS = {ADDR_EVSEL1, ADDR_EVSEL0,
    ADDR_FC_IP, ADDR_FC_SP, ADDR_FC_CS};

  // Field positions.
  localparam int MGMT_RANGE_BIT = 11;
  localparam int L2_HW_EN_BIT = 0;
  localparam int L2_INIT_BIT = 8;
  localparam int L2_ABSENT_BIT = 23;
  localparam int RESTART_BIT = 0;
  localparam int ERR_PTR_BIT = 1;
  localparam int CIP_BIT = 2;
  localparam int EV_MC_TAKEN = 0;
  localparam int EV_SHUTDOWN = 1;
  localparam int EV_FLUSH_DONE = 2;
  localparam int EV_FLUSH_IGN = 3;

  // Reset and fixed values; the capability word is arbitrary.
  localparam logic L2_INIT_RESET = 1'b0;
  localparam logic [63:0] CNT_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] ERR_CAP_VALUE = 64'h0000_0000_0000_0005;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [63:0] wdata;
  } msrb_bus_req_type;

  typedef struct packed {
    logic valid;
    logic restart_ok;
    logic error_ip;
  } msrb_mc_event_type;

  typedef struct packed {
    logic [63:0] value;
  } msrb_cnt_state_type;

  typedef struct packed {
    logic [63:0] rdata;
    logic l2_init;
    logic [2:0] err_state;
    logic shutdown;
    logic [3:0] ev_stat;
    logic [3:0] ev_mask;
    logic irq;
    logic flush_start;
    logic mc_exception;
    logic flush_n_prev;
    logic [4:0][63:0] gen;
  } msrb_state_type;

  localparam msrb_state_type STATE_RESET = '{default: '0,
    l2_init: L2_INIT_RESET, flush_n_prev: 1'b1};

endpackage
